// ==== logic/sysreg_pkg.sv ====
// Constants shared by the vector base and reset management register bank.
package sysreg_pkg;
  // Access key layout {op0[1:0], op1[2:0], crn[3:0], crm[3:0], op2[2:0]}.
  localparam int unsigned KEY_W = 16;
  localparam logic [1:0] VB2_OP0 = 2'h3;
  localparam logic [2:0] VB2_OP1 = 3'h4;
  localparam logic [3:0] VB2_CRN = 4'hC;
  localparam logic [3:0] VB2_CRM = 4'h0;
  localparam logic [2:0] VB2_OP2 = 3'h0;
  localparam logic [15:0] KEY_VB2 = {VB2_OP0, VB2_OP1, VB2_CRN, VB2_CRM,
                                     VB2_OP2};
  localparam logic [15:0] KEY_VB1 = 16'hC600;
  localparam logic [15:0] KEY_VB3 = 16'hF600;
  localparam logic [15:0] KEY_RSA = 16'hF601;
  localparam logic [15:0] KEY_RMG = 16'hF602;
  localparam logic [15:0] KEY_AI2 = 16'hE510;
  localparam logic [15:0] KEY_AI3 = 16'hF510;
  // Legacy 32-bit views carry op0 = 0.
  localparam logic [15:0] KEY_LEG_VB = 16'h0600;
  localparam logic [15:0] KEY_LEG_HVB = 16'h2600;
  localparam logic [15:0] KEY_LEG_HAL = 16'h2510;
  localparam logic [15:0] KEY_LEG_HAH = 16'h2511;
  localparam logic [15:0] KEY_LEG_PRR = 16'h0510;
  localparam logic [15:0] KEY_LEG_NRR = 16'h0511;
  // Field positions.
  localparam int unsigned VBASE_RES0_BITS = 5;
  localparam int unsigned RMG_WARM_REQ_BIT = 1;
  localparam int unsigned RMG_BOOT_SEL_BIT = 0;
  // Reset values.
  localparam logic [63:0] VBASE_RESET = 64'h0;
  localparam logic [63:0] ATTR_RESET = 64'h0;
  localparam logic [63:0] RESET_ADDR_64 = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RESET_ADDR_32 = 64'h0000_0000_FFFF_0000;
  // Start address masks: low two bits aligned, bits above 39 zero.
  localparam logic [63:0] RSA_MASK = 64'h0000_00FF_FFFF_FFFC;
  // Privilege levels.
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;
  localparam logic [1:0] EL2 = 2'h2;
  localparam logic [1:0] EL3 = 2'h3;
  typedef enum {
    SEL_NONE, SEL_VB1, SEL_VB2, SEL_VB3, SEL_RSA, SEL_RMG, SEL_AI2,
    SEL_AI3, SEL_LEG_VB, SEL_LEG_HVB, SEL_LEG_HAL, SEL_LEG_HAH,
    SEL_LEG_PRR, SEL_LEG_NRR
  } reg_sel_t;
endpackage : sysreg_pkg

// ==== logic/sysreg_word.sv ====
// One 64-bit system register word with full, low-half and high-half writes.
`timescale 1ns/1ns
`default_nettype none
module sysreg_word #(
  parameter int unsigned RES0_BITS = 0,
  parameter logic [63:0] RESET_VALUE = 64'h0
) (
  // Clock and cold reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Write strobes and data.
  input wire logic i_wr_full,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [63:0] i_wdata,
  // Stored value.
  output logic [63:0] o_value
);
  // Reserved low bits are never stored, so they always read as zero.
  localparam logic [63:0] KEEP = {64{1'b1}} << RES0_BITS;
  logic [63:0] value;
  logic [63:0] next_value;

  // Legacy half writes replace only their own word.
  always_comb begin
    next_value = value;
    if (i_wr_full) begin
      next_value = i_wdata;
    end else if (i_wr_lo) begin
      next_value[31:0] = i_wdata[31:0];
    end else if (i_wr_hi) begin
      next_value[63:32] = i_wdata[31:0];
    end
    next_value = next_value & KEEP;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      value <= RESET_VALUE & KEEP;
    end else begin
      value <= next_value;
    end
  end

  assign o_value = value;
endmodule : sysreg_word
`default_nettype wire

// ==== logic/el_access_check.sv ====
// Privilege check for one system register access.
`timescale 1ns/1ns
`default_nettype none
module el_access_check (
  // Access attributes.
  input wire logic [1:0] i_cur_el,
  input wire logic [1:0] i_min_el,
  input wire logic i_write,
  input wire logic i_read_only,
  input wire logic i_extra_ok,
  // Verdict.
  output logic o_allow
);
  // A write to a read-only register is refused like a privilege miss.
  assign o_allow = (i_cur_el >= i_min_el) && i_extra_ok &&
                   !(i_write && i_read_only);
endmodule : el_access_check
`default_nettype wire

// ==== logic/vector_base_reset_mgmt_regs.sv ====
// Vector base, attribute indirection and reset management register bank.
//
// Functional notes
// (RULE1) Level-2 attribute register: 64 bits, levels 2-3.
// (RULE2) Level-3 attribute register: 64 bits, level 3.
// (RULE3) Attribute copies in TLB may be stale.
// (RULE4) Level-2 attribute halves alias hyp legacy pair.
// (RULE5) Level-3 attribute halves alias remap pair, short format.
// (RULE6) Vector bases 64 bits, low five bits zero.
// (RULE7) Level-1 vector base: levels 1-3, level-1 exceptions.
// (RULE8) Level-2 vector base: levels 2-3, level-2 exceptions.
// (RULE9) Level-3 vector base: level 3 only.
// (RULE10) Level-1 vector low word is nonsecure legacy base.
// (RULE11) Level-2 vector low word is hyp legacy base.
// (RULE12) Level-2 vector base decoded from its fixed encoding.
// (RULE13) Start address: 64-bit, read-only at level 3.
// (RULE14) Start address bits 1:0 and 63:40 zero.
// (RULE15) Reset management: 32 bits, level 3, upper reserved.
// (RULE16) Bit 1 requests warm reset; resets clear it.
// (RULE17) Bit 0 picks boot state after warm reset.
// (RULE18) Reset vector picks between two fixed values.
// (RULE19) Cold reset loads bit 0 from boot pin.
// (RULE20) Warm request output follows the request bit.
`timescale 1ns/1ns
`default_nettype none
module vector_base_reset_mgmt_regs
  import sysreg_pkg::*;
(
  // Clock and resets.
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_warm_rst,
  // Strap sampled at cold reset.
  input wire logic i_cold_boot_state_pin,
  // System register access request.
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [KEY_W-1:0] i_req_key,
  input wire logic [63:0] i_req_wdata,
  input wire logic [1:0] i_cur_el,
  input wire logic i_nonsecure_state_bit,
  input wire logic i_long_descriptor_enable,
  // Exception entry.
  input wire logic [1:0] i_exc_target_el,
  // Access answer.
  output logic o_ack,
  output logic o_fault,
  output logic [63:0] o_rdata,
  // Values used by the core.
  output logic [63:0] o_exc_vector_base,
  output logic [63:0] o_attr_indirection_level2,
  output logic [63:0] o_attr_indirection_level3,
  output logic o_attr_changed,
  output logic [63:0] o_reset_vector,
  output logic o_boot_state_select,
  output logic o_warm_reset_request
);
  reg_sel_t sel;
  logic [1:0] min_el;
  logic read_only;
  logic extra_ok;
  logic allow;
  logic do_write;
  logic [63:0] vb1;
  logic [63:0] vb2;
  logic [63:0] vb3;
  logic [63:0] ai2;
  logic [63:0] ai3;
  logic wr_vb1_full;
  logic wr_vb1_lo;
  logic wr_vb2_full;
  logic wr_vb2_lo;
  logic wr_vb3_full;
  logic wr_ai2_full;
  logic wr_ai2_lo;
  logic wr_ai2_hi;
  logic wr_ai3_full;
  logic wr_ai3_lo;
  logic wr_ai3_hi;
  logic [63:0] read_value;
  logic [63:0] rsa_value;
  // Registered state.
  logic ack;
  logic fault;
  logic [63:0] rdata;
  logic warm_req;
  logic boot_sel;
  logic [63:0] exc_base;
  logic [63:0] reset_vec;
  logic attr_changed;
  logic next_ack;
  logic next_fault;
  logic [63:0] next_rdata;
  logic next_warm_req;
  logic next_boot_sel;
  logic [63:0] next_exc_base;
  logic [63:0] next_reset_vec;
  logic next_attr_changed;

  // The start address is a constant, masked so that its alignment and
  // physical size limits hold whatever the fixed value is.
  assign rsa_value = RESET_ADDR_64 & RSA_MASK; // RULE14

  // Decode the access key into a register selection.
  always_comb begin
    sel = SEL_NONE;
    unique case (i_req_key)
      KEY_VB1: sel = SEL_VB1;
      KEY_VB2: sel = SEL_VB2; // RULE12
      KEY_VB3: sel = SEL_VB3;
      KEY_RSA: sel = SEL_RSA;
      KEY_RMG: sel = SEL_RMG;
      KEY_AI2: sel = SEL_AI2;
      KEY_AI3: sel = SEL_AI3;
      KEY_LEG_VB: sel = SEL_LEG_VB;
      KEY_LEG_HVB: sel = SEL_LEG_HVB;
      KEY_LEG_HAL: sel = SEL_LEG_HAL;
      KEY_LEG_HAH: sel = SEL_LEG_HAH;
      KEY_LEG_PRR: sel = SEL_LEG_PRR;
      KEY_LEG_NRR: sel = SEL_LEG_NRR;
      default: sel = SEL_NONE;
    endcase
  end

  // Privilege requirements of each register and of each legacy view.
  always_comb begin
    min_el = EL3;
    read_only = 1'b0;
    extra_ok = 1'b1;
    unique case (sel)
      SEL_NONE: extra_ok = 1'b0;
      SEL_VB1: min_el = EL1; // RULE7
      SEL_VB2: min_el = EL2; // RULE8
      SEL_VB3: min_el = EL3; // RULE9
      SEL_RSA: begin
        min_el = EL3; // RULE13
        read_only = 1'b1; // RULE13
      end
      SEL_RMG: min_el = EL3; // RULE15
      SEL_AI2: min_el = EL2; // RULE1
      SEL_AI3: min_el = EL3; // RULE2
      SEL_LEG_VB: begin
        // Only the nonsecure legacy base lives here.
        min_el = EL1;
        extra_ok = i_nonsecure_state_bit; // RULE10
      end
      SEL_LEG_HVB: min_el = EL2;
      SEL_LEG_HAL: min_el = EL2;
      SEL_LEG_HAH: min_el = EL2;
      SEL_LEG_PRR: begin
        // The secure remap views exist only in the short format.
        min_el = EL1;
        extra_ok = !i_nonsecure_state_bit &&
                   !i_long_descriptor_enable; // RULE5
      end
      SEL_LEG_NRR: begin
        min_el = EL1;
        extra_ok = !i_nonsecure_state_bit &&
                   !i_long_descriptor_enable; // RULE5
      end
    endcase
  end

  el_access_check u_check (
    .i_cur_el(i_cur_el),
    .i_min_el(min_el),
    .i_write(i_req_write),
    .i_read_only(read_only),
    .i_extra_ok(extra_ok),
    .o_allow(allow)
  );

  assign do_write = i_req_valid && i_req_write && allow;

  // Write strobes; every legacy view writes the shared storage itself.
  assign wr_vb1_full = do_write && (sel == SEL_VB1);
  assign wr_vb1_lo = do_write && (sel == SEL_LEG_VB); // RULE10
  assign wr_vb2_full = do_write && (sel == SEL_VB2);
  assign wr_vb2_lo = do_write && (sel == SEL_LEG_HVB); // RULE11
  assign wr_vb3_full = do_write && (sel == SEL_VB3);
  assign wr_ai2_full = do_write && (sel == SEL_AI2);
  assign wr_ai2_lo = do_write && (sel == SEL_LEG_HAL); // RULE4
  assign wr_ai2_hi = do_write && (sel == SEL_LEG_HAH); // RULE4
  assign wr_ai3_full = do_write && (sel == SEL_AI3);
  assign wr_ai3_lo = do_write && (sel == SEL_LEG_PRR); // RULE5
  assign wr_ai3_hi = do_write && (sel == SEL_LEG_NRR); // RULE5

  // Vector bases drop their reserved low bits in storage.
  sysreg_word #(
    .RES0_BITS(VBASE_RES0_BITS),
    .RESET_VALUE(VBASE_RESET)
  ) u_vb1 (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_full(wr_vb1_full),
    .i_wr_lo(wr_vb1_lo),
    .i_wr_hi(1'b0),
    .i_wdata(i_req_wdata),
    .o_value(vb1)
  );

  sysreg_word #(
    .RES0_BITS(VBASE_RES0_BITS),
    .RESET_VALUE(VBASE_RESET)
  ) u_vb2 (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_full(wr_vb2_full),
    .i_wr_lo(wr_vb2_lo),
    .i_wr_hi(1'b0),
    .i_wdata(i_req_wdata),
    .o_value(vb2)
  );

  sysreg_word #(
    .RES0_BITS(VBASE_RES0_BITS),
    .RESET_VALUE(VBASE_RESET)
  ) u_vb3 (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_full(wr_vb3_full),
    .i_wr_lo(1'b0),
    .i_wr_hi(1'b0),
    .i_wdata(i_req_wdata),
    .o_value(vb3)
  );

  // Attribute words keep every bit.
  sysreg_word #(
    .RES0_BITS(0),
    .RESET_VALUE(ATTR_RESET)
  ) u_ai2 (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_full(wr_ai2_full),
    .i_wr_lo(wr_ai2_lo),
    .i_wr_hi(wr_ai2_hi),
    .i_wdata(i_req_wdata),
    .o_value(ai2)
  );

  sysreg_word #(
    .RES0_BITS(0),
    .RESET_VALUE(ATTR_RESET)
  ) u_ai3 (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_full(wr_ai3_full),
    .i_wr_lo(wr_ai3_lo),
    .i_wr_hi(wr_ai3_hi),
    .i_wdata(i_req_wdata),
    .o_value(ai3)
  );

  // Read data; legacy views return one 32-bit half in the low word.
  always_comb begin
    read_value = 64'h0;
    unique case (sel)
      SEL_NONE: read_value = 64'h0;
      SEL_VB1: read_value = vb1; // RULE6
      SEL_VB2: read_value = vb2; // RULE6
      SEL_VB3: read_value = vb3; // RULE6
      SEL_RSA: read_value = rsa_value; // RULE13
      SEL_RMG: begin
        read_value[RMG_WARM_REQ_BIT] = warm_req; // RULE15
        read_value[RMG_BOOT_SEL_BIT] = boot_sel; // RULE15
      end
      SEL_AI2: read_value = ai2;
      SEL_AI3: read_value = ai3;
      SEL_LEG_VB: read_value = {32'h0, vb1[31:0]};
      SEL_LEG_HVB: read_value = {32'h0, vb2[31:0]};
      SEL_LEG_HAL: read_value = {32'h0, ai2[31:0]};
      SEL_LEG_HAH: read_value = {32'h0, ai2[63:32]};
      SEL_LEG_PRR: read_value = {32'h0, ai3[31:0]};
      SEL_LEG_NRR: read_value = {32'h0, ai3[63:32]};
    endcase
  end

  // Next values of the answer, reset management and exported state.
  always_comb begin
    next_ack = i_req_valid;
    next_fault = i_req_valid && !allow;
    next_rdata = 64'h0;
    next_warm_req = warm_req;
    next_boot_sel = boot_sel;
    next_attr_changed = wr_ai2_full || wr_ai2_lo || wr_ai2_hi ||
                        wr_ai3_full || wr_ai3_lo || wr_ai3_hi; // RULE3
    if (i_req_valid && !i_req_write && allow) begin
      next_rdata = read_value;
    end
    if (do_write && (sel == SEL_RMG)) begin
      next_warm_req = i_req_wdata[RMG_WARM_REQ_BIT]; // RULE16
      next_boot_sel = i_req_wdata[RMG_BOOT_SEL_BIT]; // RULE17
    end
    // Exceptions from level 0 are taken to level 1.
    unique case (i_exc_target_el)
      EL0: next_exc_base = vb1; // RULE7
      EL1: next_exc_base = vb1; // RULE7
      EL2: next_exc_base = vb2; // RULE8
      EL3: next_exc_base = vb3; // RULE9
    endcase
    // Only two fixed targets exist, so no write can redirect reset.
    next_reset_vec = next_boot_sel ? rsa_value : RESET_ADDR_32; // RULE18
    if (i_warm_rst) begin
      next_warm_req = 1'b0; // RULE16
      next_reset_vec = boot_sel ? rsa_value : RESET_ADDR_32; // RULE18
      next_boot_sel = boot_sel;
    end
  end

  // Cold reset takes the boot strap; warm reset only drops the request.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ack <= 1'b0;
      fault <= 1'b0;
      rdata <= 64'h0;
      warm_req <= 1'b0; // RULE16
      boot_sel <= i_cold_boot_state_pin; // RULE19
      exc_base <= VBASE_RESET;
      reset_vec <= RESET_ADDR_32;
      attr_changed <= 1'b0;
    end else begin
      ack <= next_ack;
      fault <= next_fault;
      rdata <= next_rdata;
      warm_req <= next_warm_req;
      boot_sel <= next_boot_sel;
      exc_base <= next_exc_base;
      reset_vec <= next_reset_vec;
      attr_changed <= next_attr_changed;
    end
  end

  // The reset vector register lags the strap by one edge after cold reset.
  assign o_ack = ack;
  assign o_fault = fault;
  assign o_rdata = rdata;
  assign o_exc_vector_base = exc_base;
  // Live values; any translation cache must flush on o_attr_changed.
  assign o_attr_indirection_level2 = ai2; // RULE3
  assign o_attr_indirection_level3 = ai3; // RULE3
  assign o_attr_changed = attr_changed;
  assign o_reset_vector = reset_vec;
  assign o_boot_state_select = boot_sel;
  assign o_warm_reset_request = warm_req; // RULE20
endmodule : vector_base_reset_mgmt_regs
`default_nettype wire

// ==== verification/vbr_checker.sv ====
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ns
`default_nettype none
module vbr_checker
  import sysreg_pkg::*;
(
  // Clock, resets and strap.
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_warm_rst,
  input wire logic i_cold_boot_state_pin,
  // Request.
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [KEY_W-1:0] i_req_key,
  input wire logic [63:0] i_req_wdata,
  input wire logic [1:0] i_cur_el,
  // Answer and state.
  input wire logic o_ack,
  input wire logic o_fault,
  input wire logic [63:0] o_rdata,
  input wire logic [63:0] o_reset_vector,
  input wire logic o_boot_state_select,
  input wire logic o_warm_reset_request
);
  localparam logic [63:0] V64 = RESET_ADDR_64 & RSA_MASK;

  // All checks sample on the rising edge and rest while cold reset is on.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  vb2_decode_a: assert property (i_req_valid && i_req_key == KEY_VB2
    && i_cur_el >= EL2 |=> o_ack && !o_fault) else $error("vb2 refused");
  vb3_level_a: assert property (i_req_valid && i_req_key == KEY_VB3
    && i_cur_el != EL3 |=> o_fault && o_rdata == 64'h0)
    else $error("vb3 low level");
  ai2_level_a: assert property (i_req_valid && i_req_key == KEY_AI2
    && i_cur_el < EL2 |=> o_ack && o_fault) else $error("ai2 low level");
  rsa_readonly_a: assert property (i_req_valid && i_req_write
    && i_req_key == KEY_RSA |=> o_fault) else $error("rsa written");
  rsa_fixed_a: assert property (i_req_valid && !i_req_write
    && i_req_key == KEY_RSA && i_cur_el == EL3
    |=> !o_fault && o_rdata == V64) else $error("rsa value");
  // A read returns the two bits as they stood when the request was taken.
  rmg_read_a: assert property (i_req_valid && !i_req_write
    && i_req_key == KEY_RMG && i_cur_el == EL3 |=> o_rdata ==
    {62'h0, $past(o_warm_reset_request), $past(o_boot_state_select)})
    else $error("rmg read");
  warm_set_a: assert property (i_req_valid && i_req_write
    && i_req_key == KEY_RMG && i_cur_el == EL3
    |=> o_warm_reset_request ==
    ($past(i_req_wdata[1]) && !$past(i_warm_rst)))
    else $error("warm request bit");
  warm_clear_a: assert property (i_warm_rst
    |=> !o_warm_reset_request) else $error("warm not cleared");
  cold_boot_a: assert property ($fell(i_srst) |->
    o_boot_state_select == $past(i_cold_boot_state_pin))
    else $error("boot strap");
  two_vectors_a: assert property (o_reset_vector == V64
    || o_reset_vector == RESET_ADDR_32) else $error("stray vector");
  boot_vector_a: assert property ($stable(o_boot_state_select)
    && !$past(i_srst) |-> o_reset_vector ==
    (o_boot_state_select ? V64 : RESET_ADDR_32)) else $error("vector");

  c_fault: cover property (o_ack && o_fault);
  c_warm: cover property ($fell(o_warm_reset_request));
  c_boot: cover property ($rose(o_boot_state_select));
endmodule : vbr_checker

bind vector_base_reset_mgmt_regs vbr_checker u_chk (.i_clk(i_clk),
  .i_srst(i_srst), .i_warm_rst(i_warm_rst), .i_req_valid(i_req_valid),
  .i_cold_boot_state_pin(i_cold_boot_state_pin), .i_cur_el(i_cur_el),
  .i_req_write(i_req_write), .i_req_key(i_req_key), .o_ack(o_ack),
  .i_req_wdata(i_req_wdata), .o_fault(o_fault), .o_rdata(o_rdata),
  .o_reset_vector(o_reset_vector), .o_boot_state_select(o_boot_state_select),
  .o_warm_reset_request(o_warm_reset_request));
`default_nettype wire

// ==== verification/core_model.sv ====
// Core model that issues system register accesses to the bank.
`timescale 1ns/1ns
`default_nettype none
module core_model
  import sysreg_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Request toward the bank.
  output logic o_req_valid,
  output logic o_req_write,
  output logic [KEY_W-1:0] o_req_key,
  output logic [63:0] o_req_wdata,
  output logic [1:0] o_cur_el,
  output logic o_ns,
  output logic o_lde,
  // Answer from the bank.
  input wire logic i_ack,
  input wire logic i_fault,
  input wire logic [63:0] i_rdata
);
  // Idle until the first access.
  initial begin
    o_req_valid = 1'b0;
    o_req_write = 1'b0;
    o_req_key = '0;
    o_req_wdata = '0;
    o_cur_el = EL0;
    o_ns = 1'b0;
    o_lde = 1'b0;
  end

  // Idle cycles first model a slow core; key and data are inverted once
  // released so that a stale value cannot pass for a held one.
  task automatic access(input logic w, input logic [15:0] k,
    input logic [63:0] d, input logic [1:0] e, input logic n,
    input logic l, input int gap, output logic ok, output logic f,
    output logic [63:0] rd);
    ok = 1'b0;
    f = 1'b0;
    rd = '0;
    repeat (gap) @(posedge i_clk);
    o_req_valid <= 1'b1;
    o_req_write <= w;
    o_req_key <= k;
    o_req_wdata <= d;
    o_cur_el <= e;
    o_ns <= n;
    o_lde <= l;
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    o_req_key <= ~k;
    o_req_wdata <= ~d;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge i_clk);
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        f = i_fault;
        rd = i_rdata;
      end
    end
  endtask : access
endmodule : core_model
`default_nettype wire

// ==== verification/vector_base_reset_mgmt_regs_tb_top.sv ====
// Self-checking bench for the vector base and reset management bank.
`timescale 1ns/1ns
`default_nettype none
module vector_base_reset_mgmt_regs_tb_top import sysreg_pkg::*;;
  localparam logic [63:0] V64 = RESET_ADDR_64 & RSA_MASK;
  logic i_clk = 1'b0;
  logic srst = 1'b1;
  logic warm = 1'b0;
  logic pin = 1'b0;
  logic [1:0] exc = 2'h0;
  logic valid, wr, ns, lde, ack, fault, boot, wreq, chg;
  logic [1:0] el;
  logic [15:0] key;
  logic [63:0] wd, rdata, ebase, ai2o, ai3o, rvec, ai2, ai3;
  logic [63:0] vb [1:3];
  logic [1:0] rm;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] keys [14] = '{KEY_VB1, KEY_VB2, KEY_VB3, KEY_RSA, KEY_RMG,
    KEY_AI2, KEY_AI3, KEY_LEG_VB, KEY_LEG_HVB, KEY_LEG_HAL, KEY_LEG_HAH,
    KEY_LEG_PRR, KEY_LEG_NRR, 16'h1234};

  // Free-running clock.
  always #10 i_clk = ~i_clk;

  core_model core (.i_clk(i_clk), .o_req_valid(valid), .o_req_write(wr),
    .o_req_key(key), .o_req_wdata(wd), .o_cur_el(el), .o_ns(ns),
    .o_lde(lde), .i_ack(ack), .i_fault(fault), .i_rdata(rdata));
  vector_base_reset_mgmt_regs dut (.i_clk(i_clk), .i_srst(srst),
    .i_warm_rst(warm), .i_cold_boot_state_pin(pin), .i_req_valid(valid),
    .i_req_write(wr), .i_req_key(key), .i_req_wdata(wd), .i_cur_el(el),
    .i_nonsecure_state_bit(ns), .i_long_descriptor_enable(lde),
    .i_exc_target_el(exc), .o_ack(ack), .o_fault(fault), .o_rdata(rdata),
    .o_exc_vector_base(ebase), .o_attr_indirection_level2(ai2o),
    .o_attr_indirection_level3(ai3o), .o_attr_changed(chg),
    .o_reset_vector(rvec), .o_boot_state_select(boot),
    .o_warm_reset_request(wreq));

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Privilege and view gating that an access must pass.
  function automatic logic allowed(logic [15:0] k, logic w, logic [1:0] e,
    logic n, logic l);
    case (k)
      KEY_VB1: return e >= EL1;
      KEY_VB2, KEY_AI2, KEY_LEG_HVB: return e >= EL2;
      KEY_LEG_HAL, KEY_LEG_HAH: return e >= EL2;
      KEY_VB3, KEY_AI3, KEY_RMG: return e == EL3;
      KEY_RSA: return e == EL3 && !w;
      KEY_LEG_VB: return e >= EL1 && n;
      KEY_LEG_PRR, KEY_LEG_NRR: return e >= EL1 && !n && !l;
      default: return 1'b0;
    endcase
  endfunction : allowed

  function automatic logic [63:0] rdval(logic [15:0] k);
    case (k)
      KEY_VB1: return vb[1];
      KEY_VB2: return vb[2];
      KEY_VB3: return vb[3];
      KEY_RSA: return V64;
      KEY_RMG: return {62'h0, rm};
      KEY_AI2: return ai2;
      KEY_AI3: return ai3;
      KEY_LEG_VB: return {32'h0, vb[1][31:0]};
      KEY_LEG_HVB: return {32'h0, vb[2][31:0]};
      KEY_LEG_HAL: return {32'h0, ai2[31:0]};
      KEY_LEG_HAH: return {32'h0, ai2[63:32]};
      KEY_LEG_PRR: return {32'h0, ai3[31:0]};
      default: return {32'h0, ai3[63:32]};
    endcase
  endfunction : rdval

  // Shadow update; vector bases never keep their low five bits.
  task automatic upd(input logic [15:0] k, input logic [63:0] d);
    logic [63:0] v;
    v = d & ~64'h1F;
    case (k)
      KEY_VB1: vb[1] = v;
      KEY_VB2: vb[2] = v;
      KEY_VB3: vb[3] = v;
      KEY_RMG: rm = d[1:0];
      KEY_AI2: ai2 = d;
      KEY_AI3: ai3 = d;
      KEY_LEG_VB: vb[1][31:0] = v[31:0];
      KEY_LEG_HVB: vb[2][31:0] = v[31:0];
      KEY_LEG_HAL: ai2[31:0] = d[31:0];
      KEY_LEG_HAH: ai2[63:32] = d[31:0];
      KEY_LEG_PRR: ai3[31:0] = d[31:0];
      KEY_LEG_NRR: ai3[63:32] = d[31:0];
      default: ;
    endcase
  endtask : upd

  task automatic acc(input logic w, input logic [15:0] k,
    input logic [63:0] d, input logic [1:0] e, input logic n, input logic l);
    logic ok, f, a, at;
    logic [63:0] rd, x;
    a = allowed(k, w, e, n, l);
    // Any accepted write into an attribute word must flag cached copies.
    at = a && w && (k inside {KEY_AI2, KEY_AI3, KEY_LEG_HAL, KEY_LEG_HAH,
      KEY_LEG_PRR, KEY_LEG_NRR});
    x = (a && !w) ? rdval(k) : 64'h0;
    exc <= 2'($urandom);
    pin <= 1'($urandom);
    core.access(w, k, d, e, n, l, $urandom_range(2), ok, f, rd);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t no answer", $time);
      report_and_stop();
    end
    chk({63'h0, f}, {63'h0, !a});
    chk(rd, x);
    chk({63'h0, chg}, {63'h0, at});
    if (a && w) upd(k, d);
    @(posedge i_clk);
    chk(ai2o, ai2);
    chk(ai3o, ai3);
    chk({62'h0, wreq, boot}, {62'h0, rm});
    chk(ebase, vb[exc == 2'h0 ? 1 : exc]);
    chk(rvec, rm[0] ? V64 : RESET_ADDR_32);
  endtask : acc

  // A warm reset drops only the request bit.
  task automatic warm_pulse();
    warm <= 1'b1;
    @(posedge i_clk);
    warm <= 1'b0;
    rm[1] = 1'b0;
    repeat (2) @(posedge i_clk);
    chk({62'h0, wreq, boot}, {62'h0, rm});
  endtask : warm_pulse

  task automatic cold(input logic p);
    srst <= 1'b1;
    pin <= p;
    repeat (20) @(posedge i_clk);
    srst <= 1'b0;
    vb = '{default: 64'h0};
    ai2 = '0;
    ai3 = '0;
    rm = {1'b0, p};
    @(posedge i_clk);
    chk({63'h0, boot}, {63'h0, p});
  endtask : cold

  // Two cold boots with each strap level, then corners and random traffic.
  initial begin
    void'($urandom(32'h7184));
    for (int r = 1; r >= 0; r--) begin
      cold(r[0]);
      for (int i = 0; i < 14; i++) acc(1'b0, keys[i], '0, EL3, 1'b0, 1'b0);
      acc(1'b1, KEY_RSA, '1, EL3, 1'b0, 1'b0);
      acc(1'b1, KEY_RMG, 64'h3, EL3, 1'b0, 1'b0);
      warm_pulse();
      for (int i = 0; i < 300; i++) begin
        acc(1'($urandom), keys[$urandom_range(13)], {$urandom, $urandom},
          2'($urandom), 1'($urandom), 1'($urandom));
        if ($urandom_range(7) == 0) warm_pulse();
      end
    end
    report_and_stop();
  end
endmodule : vector_base_reset_mgmt_regs_tb_top
`default_nettype wire
